// File: hdl/dpt_tester_if.sv
/*
 pin interface of a stand-alone tester driving eight 2k x 8 dual-port rams.
 assumes the rams arbitrate contention and keep their own mailbox latches;
 a sequencer on core_clk issues one access request at a time.
*/
`timescale 1ns/1ns
`include "dpt_defines.svh"
module dpt_tester_if (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire dpt_pkg::dpt_req_s        req,
  input  wire logic                     cnt_load,
  input  wire logic [`DPT_ADDR_W-1:0]   cnt_load_val,
  input  wire logic                     cnt_inc,
  input  wire logic [1:0]               addr_src,
  input  wire logic [`DPT_HI_AW-1:0]    addr_out_reg,
  input  wire logic [`DPT_CC_W-1:0]     condition_inputs,
  input  wire logic [`DPT_DATA_W-1:0]   host_side_data_bus_i,
  output logic      [`DPT_DATA_W-1:0]   host_side_data_bus_o,
  output logic      [`DPT_DATA_W-1:0]   host_side_data_bus_oe,
  output logic      [`DPT_HI_AW-1:0]    addr_bus,
  output logic      [`DPT_LO_AW-1:0]    host_side_address_bus_o,
  output logic      [`DPT_LO_AW-1:0]    host_side_address_bus_oe,
  output logic      [`DPT_CE_W-1:0]     output_control_lines,
  output logic      [`DPT_IO_W-1:0]     gen_io_o,
  output logic      [`DPT_IO_W-1:0]     gen_io_oe,
  output logic                          ready,
  output logic                          done,
  output logic      [`DPT_BYTE_W-1:0]   left_rdata,
  output logic      [`DPT_BYTE_W-1:0]   right_rdata,
  output dpt_pkg::dpt_cond_s            cond,
  output logic                          busy_seen
);

////////////////////////////////////////////////////////////////////////////////
// helpers

  function automatic logic [`DPT_HI_AW-1:0] pick_high(
    input logic [1:0]             src,
    input logic [`DPT_ADDR_W-1:0] cnt,
    input logic [`DPT_HI_AW-1:0]  aor
  );
    case (src)
      `DPT_SRC_AOR: pick_high = aor;
      default:      pick_high = cnt[`DPT_ADDR_W-1:`DPT_LO_AW];
    endcase
  endfunction

  function automatic logic group_busy(
    input dpt_pkg::dpt_cond_s c,
    input logic               le,
    input logic               re
  );
    group_busy = (le & (~c.busy_l_a | ~c.busy_l_b)) |
                 (re & (~c.busy_r_a | ~c.busy_r_b));
  endfunction

////////////////////////////////////////////////////////////////////////////////
// condition inputs

  logic [`DPT_CC_W-1:0] cc_sync;

  dpt_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (condition_inputs),
    .sync_out (cc_sync)
  );

  dpt_pkg::dpt_cond_s cond_r;
  dpt_pkg::dpt_cond_s cond_nxt;

  always_comb begin
    cond_nxt.busy_l_a = cc_sync[`DPT_CC_BUSY_L_A];
    cond_nxt.busy_r_a = cc_sync[`DPT_CC_BUSY_R_A];
    cond_nxt.busy_l_b = cc_sync[`DPT_CC_BUSY_L_B];
    cond_nxt.busy_r_b = cc_sync[`DPT_CC_BUSY_R_B];
    cond_nxt.int_l_a  = cc_sync[`DPT_CC_INT_L_A];
    cond_nxt.int_r_a  = cc_sync[`DPT_CC_INT_R_A];
    cond_nxt.int_l_b  = cc_sync[`DPT_CC_INT_L_B];
    cond_nxt.int_r_b  = cc_sync[`DPT_CC_INT_R_B];
  end

////////////////////////////////////////////////////////////////////////////////
// address counter

  logic [`DPT_ADDR_W-1:0] cnt_r;
  logic [`DPT_ADDR_W-1:0] cnt_nxt;
  logic [`DPT_HI_AW-1:0]  abus_r;
  logic [`DPT_HI_AW-1:0]  abus_nxt;
  logic [`DPT_LO_AW-1:0]  hab_r;
  logic [`DPT_LO_AW-1:0]  hab_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (cnt_load) begin
      cnt_nxt = cnt_load_val;
    end else if (cnt_inc) begin
      cnt_nxt = cnt_r + `DPT_ONE_ADDR;
    end
    // upper 11 of addr_bus go left, lower 5 plus host bus go right
    abus_nxt = pick_high(addr_src, cnt_nxt, addr_out_reg);
    hab_nxt  = cnt_nxt[`DPT_LO_AW-1:0];
  end

////////////////////////////////////////////////////////////////////////////////
// access sequencer

  dpt_pkg::dpt_state_e     st_r;
  dpt_pkg::dpt_state_e     st_nxt;
  logic                    wr_r;
  logic                    wr_nxt;
  logic                    le_r;
  logic                    le_nxt;
  logic                    re_r;
  logic                    re_nxt;
  logic [`DPT_BYTE_W-1:0]  sel_r;
  logic [`DPT_BYTE_W-1:0]  sel_nxt;
  logic [`DPT_DATA_W-1:0]  wdata_r;
  logic [`DPT_DATA_W-1:0]  wdata_nxt;
  logic [`DPT_CE_W-1:0]    ce_r;
  logic [`DPT_CE_W-1:0]    ce_nxt;
  logic [`DPT_IO_W-1:0]    io_r;
  logic [`DPT_IO_W-1:0]    io_nxt;
  logic [`DPT_DATA_W-1:0]  doe_r;
  logic [`DPT_DATA_W-1:0]  doe_nxt;
  logic [`DPT_BYTE_W-1:0]  lrd_r;
  logic [`DPT_BYTE_W-1:0]  lrd_nxt;
  logic [`DPT_BYTE_W-1:0]  rrd_r;
  logic [`DPT_BYTE_W-1:0]  rrd_nxt;
  logic                    rdy_r;
  logic                    rdy_nxt;
  logic                    done_r;
  logic                    done_nxt;
  logic                    bsy_r;
  logic                    bsy_nxt;
  logic                    active;
  logic                    lon;
  logic                    ron;
  logic                    stall;

  always_comb begin
    st_nxt    = st_r;
    wr_nxt    = wr_r;
    le_nxt    = le_r;
    re_nxt    = re_r;
    sel_nxt   = sel_r;
    wdata_nxt = wdata_r;
    lrd_nxt   = lrd_r;
    rrd_nxt   = rrd_r;
    done_nxt  = 1'b0;
    stall     = group_busy(cond_r, le_r, re_r);
    bsy_nxt   = stall;
    case (st_r)
      dpt_pkg::DPT_IDLE: begin
        if (req.go) begin
          st_nxt    = dpt_pkg::DPT_SETUP;
          wr_nxt    = req.wr;
          le_nxt    = req.left_en;
          re_nxt    = req.right_en;
          sel_nxt   = req.sel;
          wdata_nxt = {req.left_wdata, req.right_wdata};
        end
      end
      dpt_pkg::DPT_SETUP: begin
        st_nxt = dpt_pkg::DPT_HOLD;
      end
      dpt_pkg::DPT_HOLD: begin
        if (!stall) begin
          st_nxt = dpt_pkg::DPT_DONE;
          if (!wr_r) begin
            lrd_nxt = host_side_data_bus_i[`DPT_DATA_W-1:`DPT_BYTE_W];
            rrd_nxt = host_side_data_bus_i[`DPT_BYTE_W-1:0];
          end
        end
      end
      dpt_pkg::DPT_DONE: begin
        st_nxt   = dpt_pkg::DPT_RECOV;
        done_nxt = 1'b1;
      end
      dpt_pkg::DPT_RECOV: begin
        st_nxt = dpt_pkg::DPT_IDLE;
      end
      default: begin
        st_nxt = dpt_pkg::DPT_IDLE;
      end
    endcase
    active  = (st_nxt == dpt_pkg::DPT_SETUP) || (st_nxt == dpt_pkg::DPT_HOLD);
    // chip enables, strobes and data drive all come from one state in one cycle
    // a side with no memory selected keeps its strobes and data drive off
    lon     = active && le_nxt && (sel_nxt != `DPT_ZERO_BYTE);
    ron     = active && re_nxt && (sel_nxt != `DPT_ZERO_BYTE);
    ce_nxt  = {lon ? ~sel_nxt : `DPT_ALL_OFF,
               ron ? ~sel_nxt : `DPT_ALL_OFF};
    io_nxt  = `DPT_ALL_OFF;
    io_nxt[`DPT_IO_RW_L] = ~(lon && wr_nxt);
    io_nxt[`DPT_IO_RW_R] = ~(ron && wr_nxt);
    io_nxt[`DPT_IO_OE_L] = ~(lon && !wr_nxt);
    io_nxt[`DPT_IO_OE_R] = ~(ron && !wr_nxt);
    doe_nxt = {{`DPT_BYTE_W{lon && wr_nxt}},
               {`DPT_BYTE_W{ron && wr_nxt}}};
    rdy_nxt = (st_nxt == dpt_pkg::DPT_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r    <= dpt_pkg::DPT_IDLE;
      cond_r  <= `DPT_ALL_OFF;
      cnt_r   <= `DPT_ZERO_ADDR;
      abus_r  <= `DPT_ZERO_WORD;
      hab_r   <= '0;
      wr_r    <= 1'b0;
      le_r    <= 1'b0;
      re_r    <= 1'b0;
      sel_r   <= `DPT_ZERO_BYTE;
      wdata_r <= `DPT_ZERO_WORD;
      ce_r    <= {`DPT_ALL_OFF, `DPT_ALL_OFF};
      io_r    <= `DPT_ALL_OFF;
      doe_r   <= `DPT_ZERO_WORD;
      lrd_r   <= `DPT_ZERO_BYTE;
      rrd_r   <= `DPT_ZERO_BYTE;
      rdy_r   <= 1'b0;
      done_r  <= 1'b0;
      bsy_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cond_r  <= cond_nxt;
      cnt_r   <= cnt_nxt;
      abus_r  <= abus_nxt;
      hab_r   <= hab_nxt;
      wr_r    <= wr_nxt;
      le_r    <= le_nxt;
      re_r    <= re_nxt;
      sel_r   <= sel_nxt;
      wdata_r <= wdata_nxt;
      ce_r    <= ce_nxt;
      io_r    <= io_nxt;
      doe_r   <= doe_nxt;
      lrd_r   <= lrd_nxt;
      rrd_r   <= rrd_nxt;
      rdy_r   <= rdy_nxt;
      done_r  <= done_nxt;
      bsy_r   <= bsy_nxt;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// outputs

  assign host_side_data_bus_o     = wdata_r;
  assign host_side_data_bus_oe    = doe_r;
  assign addr_bus                 = abus_r;
  assign host_side_address_bus_o  = hab_r;
  assign host_side_address_bus_oe = {`DPT_LO_AW{1'b1}};
  assign output_control_lines     = ce_r;
  assign gen_io_o                 = io_r;
  assign gen_io_oe                = {`DPT_IO_W{1'b1}};
  assign ready                    = rdy_r;
  assign done                     = done_r;
  assign left_rdata               = lrd_r;
  assign right_rdata              = rrd_r;
  assign cond                     = cond_r;
  assign busy_seen                = bsy_r;
endmodule

// File: inc/dpt_defines.svh
/*
 constants for the dual-port ram tester pin interface.
 assumes inclusion by bare name from any design or bench file.
*/
`ifndef DPT_DEFINES_SVH
`define DPT_DEFINES_SVH
`define DPT_ADDR_W      22
`define DPT_PORT_AW     11
`define DPT_HI_AW       16
`define DPT_LO_AW       6
`define DPT_DATA_W      16
`define DPT_BYTE_W      8
`define DPT_NUM_MEM     8
`define DPT_CE_W        16
`define DPT_CC_W        8
`define DPT_IO_W        8
`define DPT_IO_RW_L     7
`define DPT_IO_RW_R     6
`define DPT_IO_OE_L     5
`define DPT_IO_OE_R     4
`define DPT_CC_BUSY_L_A 7
`define DPT_CC_BUSY_R_A 6
`define DPT_CC_BUSY_L_B 5
`define DPT_CC_BUSY_R_B 4
`define DPT_CC_INT_L_A  3
`define DPT_CC_INT_R_A  2
`define DPT_CC_INT_L_B  1
`define DPT_CC_INT_R_B  0
`define DPT_SRC_HIGH    2'h0
`define DPT_SRC_FULL    2'h1
`define DPT_SRC_AOR     2'h2
`define DPT_ONE_ADDR    22'h00_0001
`define DPT_ZERO_ADDR   22'h00_0000
`define DPT_ZERO_BYTE   8'h00
`define DPT_ZERO_WORD   16'h0000
`define DPT_ALL_OFF     8'hff
`define DPT_RST_MIN     2
`endif

// File: inc/dpt_pkg.sv
/*
 types for the dual-port ram tester pin interface.
 assumes dpt_defines.svh is on the include path.
*/
`include "dpt_defines.svh"
package dpt_pkg;
  typedef enum logic [4:0] {
    DPT_IDLE  = 5'b0_0001,
    DPT_SETUP = 5'b0_0010,
    DPT_HOLD  = 5'b0_0100,
    DPT_DONE  = 5'b0_1000,
    DPT_RECOV = 5'b1_0000
  } dpt_state_e;

  typedef struct packed {
    logic                    go;
    logic                    wr;
    logic                    left_en;
    logic                    right_en;
    logic [`DPT_BYTE_W-1:0]  sel;
    logic [`DPT_BYTE_W-1:0]  left_wdata;
    logic [`DPT_BYTE_W-1:0]  right_wdata;
  } dpt_req_s;

  typedef struct packed {
    logic busy_l_a;
    logic busy_r_a;
    logic busy_l_b;
    logic busy_r_b;
    logic int_l_a;
    logic int_r_a;
    logic int_l_b;
    logic int_r_b;
  } dpt_cond_s;
endpackage

// File: hdl/dpt_sync.sv
/*
 two-flop synchroniser for a vector of pin levels.
 assumes the inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ns
`include "dpt_defines.svh"
module dpt_sync (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [`DPT_CC_W-1:0]   async_in,
  output logic      [`DPT_CC_W-1:0]   sync_out
);
  logic [`DPT_CC_W-1:0] meta_r;
  logic [`DPT_CC_W-1:0] meta_nxt;
  logic [`DPT_CC_W-1:0] sync_r;
  logic [`DPT_CC_W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // inactive busy/interrupt lines idle high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= `DPT_ALL_OFF;
      sync_r <= `DPT_ALL_OFF;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

// File: sim/dpt_props.sv
/* checker for the tester pin interface.
   bound to dpt_tester_if, sees its ports only. */
`timescale 1ns/1ns
module dpt_props (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire dpt_pkg::dpt_req_s  req,
  input wire logic               cnt_load,
  input wire logic [21:0]        cnt_load_val,
  input wire logic [1:0]         addr_src,
  input wire logic [7:0]         condition_inputs,
  input wire logic [15:0]        host_side_data_bus_oe,
  input wire logic [15:0]        addr_bus,
  input wire logic [5:0]         host_side_address_bus_o,
  input wire logic [15:0]        output_control_lines,
  input wire logic [7:0]         gen_io_o,
  input wire logic               ready,
  input wire logic               done,
  input wire dpt_pkg::dpt_cond_s cond
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_ADDR_SPLIT: assert property (
    $past(cnt_load) && !$past(rst) && $past(addr_src) != 2'h2
    |-> {addr_bus, host_side_address_bus_o} == $past(cnt_load_val)) else $error("addr split");
  AST_IDLE_CTRL: assert property (
    ready |-> output_control_lines == 16'hffff && gen_io_o == 8'hff) else $error("idle ctrl");
  AST_RESET_STATE: assert property (
    disable iff (1'b0) rst |=> output_control_lines == 16'hffff && !ready && !done)
    else $error("reset state");
  AST_TAKE_DONE: assert property (
    ready && req.go |=> (!ready && !done) [*3] ##[1:60] done) else $error("access length");
  AST_DONE_PULSE: assert property (
    done |-> !ready ##1 !done && ready) else $error("done pulse");
  AST_WR_DRIVES: assert property (
    (gen_io_o[7] || host_side_data_bus_oe[15:8] == 8'hff) &&
    (gen_io_o[6] || host_side_data_bus_oe[7:0] == 8'hff)) else $error("write without drive");
  AST_STROBE_SEL: assert property (
    (gen_io_o[7] || output_control_lines[15:8] != 8'hff) &&
    (gen_io_o[6] || output_control_lines[7:0] != 8'hff)) else $error("strobe no select");
  AST_DATA_DRIVE: assert property (
    host_side_data_bus_oe != 16'h0000 |-> gen_io_o[7:6] != 2'b11 && gen_io_o[5:4] == 2'b11)
    else $error("data drive");
  AST_COND_LAT: assert property (
    !$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3)
    |-> cond == $past(condition_inputs, 3)) else $error("cond latency");
endmodule
bind dpt_tester_if dpt_props u_props (.core_clk, .rst, .req, .cnt_load, .cnt_load_val,
  .addr_src, .condition_inputs, .host_side_data_bus_oe, .addr_bus, .host_side_address_bus_o,
  .output_control_lines, .gen_io_o, .ready, .done, .cond);

// File: sim/dpt_ram_model.sv
/* eight dual-port rams as seen from the tester pins.
   assumes active-low controls; busy_cmd lets the bench hold busy. */
`timescale 1ns/1ns
module dpt_ram_model (
  input  wire logic [15:0] ce_n,
  input  wire logic        core_clk,
  input  wire logic [7:0]  io,
  input  wire logic [15:0] addr_bus,
  input  wire logic [5:0]  haddr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  busy_cmd,
  output logic      [15:0] rdata,
  output logic      [7:0]  cc_n
);
  logic [7:0]  mem [8][2048];
  logic [7:0]  int_l;
  logic [7:0]  int_r;
  logic [15:0] last;
  logic [10:0] la;
  logic [10:0] ra;
  logic        hit;
  assign la = addr_bus[15:5];
  assign ra = {addr_bus[4:0], haddr};
  // right side loses a same-cell clash
  assign hit = ((~ce_n[15:8] & ~ce_n[7:0]) != 8'h00) && la == ra;
  assign cc_n = {~busy_cmd[1], ~(busy_cmd[0] | hit), ~busy_cmd[1], ~(busy_cmd[0] | hit),
                 ~|int_l[3:0], ~|int_r[3:0], ~|int_l[7:4], ~|int_r[7:4]};
  initial begin
    int_l = 8'h00;
    int_r = 8'h00;
    last = 16'h0000;
  end
  always @(posedge core_clk) begin
    last <= rdata;
    for (int k = 0; k < 8; k++) begin
      if (!ce_n[8+k] && !io[7] && !busy_cmd[1]) begin
        mem[k][la] <= wdata[15:8];
        if (la == 11'h7ff) int_r[k] <= 1'b1;
      end
      if (!ce_n[k] && !io[6] && !busy_cmd[0] && !hit) begin
        mem[k][ra] <= wdata[7:0];
        if (ra == 11'h7fe) int_l[k] <= 1'b1;
      end
      if (!ce_n[8+k] && !io[5] && la == 11'h7fe) int_l[k] <= 1'b0;
      if (!ce_n[k] && !io[4] && ra == 11'h7ff) int_r[k] <= 1'b0;
    end
  end
  // undriven bytes toggle every cycle
  always_comb begin
    rdata = ~last;
    for (int k = 0; k < 8; k++) begin
      if (!ce_n[8+k] && !io[5] && io[7]) rdata[15:8] = mem[k][la];
      if (!ce_n[k] && !io[4] && io[6]) rdata[7:0] = mem[k][ra];
    end
  end
endmodule

// File: sim/dpt_tb.sv
/* self-checking bench for dpt_tester_if with the ram model on its pins.
   assumes one access at a time from the sequencer side. */
`timescale 1ns/1ns
module tb;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  dpt_pkg::dpt_req_s  req = '0;
  logic               cnt_load = 1'b0;
  logic               cnt_inc = 1'b0;
  logic [21:0]        cnt_load_val = '0;
  logic [1:0]         addr_src = 2'h1;
  logic [1:0]         busy_cmd = 2'h0;
  logic [15:0]        addr_out_reg = 16'h0000;
  logic [15:0]        hd_i, hd_o, addr_bus, ce_n;
  logic [5:0]         ha_o, ha_oe;
  logic [7:0]         cc_n, io_o, io_oe, l_rd, r_rd;
  logic               ready, done, busy_seen;
  dpt_pkg::dpt_cond_s cond;
  int                 n_errors = 0;
  int                 compares = 0;
  int                 cyc = 0;
  int                 n;
  dpt_tester_if dut (.core_clk, .rst, .req, .cnt_load, .cnt_load_val, .cnt_inc, .addr_src,
    .addr_out_reg, .condition_inputs(cc_n), .host_side_data_bus_i(hd_i),
    .host_side_data_bus_o(hd_o), .host_side_data_bus_oe(), .addr_bus,
    .host_side_address_bus_o(ha_o), .host_side_address_bus_oe(ha_oe),
    .output_control_lines(ce_n), .gen_io_o(io_o), .gen_io_oe(io_oe), .ready, .done,
    .left_rdata(l_rd), .right_rdata(r_rd), .cond, .busy_seen);
  dpt_ram_model ram (.ce_n, .core_clk, .io(io_o), .addr_bus, .haddr(ha_o), .wdata(hd_o),
    .busy_cmd, .rdata(hd_i), .cc_n);
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // m = {write, left_en, right_en}; n counts negedges until done
  task automatic acc(input logic [2:0] m, input logic [21:0] a, input logic [7:0] s,
                     input logic [15:0] wd);
    n = 0;
    while (ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cnt_load <= 1'b1;
    cnt_load_val <= a;
    @(posedge core_clk);
    cnt_load <= 1'b0;
    req <= {1'b1, m, s, wd};
    @(negedge core_clk);
    chk({addr_bus, ha_o}, a);
    @(posedge core_clk);
    req.go <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 100);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk({ce_n, io_o, ready}, {16'hffff, 8'hff, 1'b0});
    chk({io_oe, ha_oe}, {8'hff, 6'h3f});
    @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task automatic s_rw();
    acc(3'b111, {11'h123, 11'h456}, 8'h01, 16'ha55a);
    chk(n, 4);
    acc(3'b011, {11'h123, 11'h456}, 8'h01, 16'h0000);
    chk({l_rd, r_rd}, 16'ha55a);
    acc(3'b111, {11'h7a0, 11'h05f}, 8'hff, 16'h6699);
    for (int i = 0; i < 8; i++) begin
      acc(3'b011, {11'h7a0, 11'h05f}, 8'h01 << i, 16'h0000);
      chk({l_rd, r_rd}, 16'h6699);
    end
    // both ports on one cell: right loses, its busy shows three cycles later
    acc(3'b111, {11'h0aa, 11'h0aa}, 8'h01, 16'h1122);
    chk(cond, 8'haf);
    acc(3'b011, {11'h0aa, 11'h0aa}, 8'h01, 16'h0000);
    chk({l_rd, r_rd}, 16'h1111);
  endtask
  task automatic s_src();
    @(posedge core_clk);
    addr_src <= 2'h2;
    addr_out_reg <= 16'hbeef;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(addr_bus, 16'hbeef);
    @(posedge core_clk);
    addr_src <= 2'h0;
    cnt_inc <= 1'b1;
    @(posedge core_clk);
    cnt_inc <= 1'b0;
    @(negedge core_clk);
    chk({addr_bus, ha_o}, {11'h0aa, 11'h0ab});
  endtask
  task automatic s_busy();
    @(posedge core_clk);
    busy_cmd <= 2'b10;
    repeat (4) @(negedge core_clk);
    chk(cond, 8'h5f);
    fork
      acc(3'b010, {11'h123, 11'h000}, 8'h01, 16'h0000);
      begin
        repeat (11) @(negedge core_clk);
        chk(busy_seen, 1'b1);
        @(posedge core_clk);
        busy_cmd <= 2'b00;
      end
    join
    chk(n > 10, 1'b1);
    chk(l_rd, 8'ha5);
  endtask
  task automatic s_int();
    logic [2:0]  m [4] = '{3'b110, 3'b001, 3'b101, 3'b010};
    logic [21:0] a [4] = '{{11'h7ff, 11'h000}, {11'h000, 11'h7ff},
                           {11'h000, 11'h7fe}, {11'h7fe, 11'h000}};
    logic [7:0]  s [4] = '{8'h01, 8'h01, 8'h10, 8'h10};
    logic [7:0]  e [4] = '{8'hfb, 8'hff, 8'hfd, 8'hff};
    for (int i = 0; i < 4; i++) begin
      acc(m[i], a[i], s[i], 16'h3c3c);
      repeat (4) @(negedge core_clk);
      chk(cond, e[i]);
    end
  endtask
  initial begin
    do_reset();
    s_rw();
    s_src();
    s_busy();
    s_int();
    do_reset();
    summarize();
  end
endmodule
